// ### src/swd_pkg.sv
// Purpose: Shared constants and carriers for the sine-wave drive generator
// Assumes: 200 MHz system clock, synchronous active-high reset
// Notes: Analogue levels arrive as 8-bit codes, 0x00 = 0.5 V, 0xFF = 4.5 V
package swd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int PWM_PERIOD_CYC = 64;
  localparam int PWM_HALF_CYC = PWM_PERIOD_CYC / 2;
  // Hall period counter prescale per range: 0 -> /4, 1 -> /8, 2 -> /1
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic [3:0] PRESC_R00 = 4'h3;
  localparam logic [3:0] PRESC_R01 = 4'h7;
  localparam logic [3:0] PRESC_R1X = 4'h0;
  localparam logic [15:0] HALL_PER_MAX = 16'hFFFF;
  localparam logic [15:0] HALL_PER_MIN = 16'h0040;
  // ----------------------------------------
  // Level thresholds, code = (V - 0.5) * 255 / 4
  // ----------------------------------------
  localparam logic [7:0] DUTY_ON_CODE = 8'h10;   // 0.75 V
  localparam logic [7:0] DUTY_OFF_CODE = 8'h0A;  // 0.65 V
  localparam logic [4:0] LEAD_OFF_CODE = 5'h00;  // 0.2 V, below scale
  // ----------------------------------------
  // Register bit positions
  // ----------------------------------------
  localparam int MOD_MANUAL_BIT = 7;
  localparam int MOD_FORCE_SINE_BIT = 6;
  localparam int DRV_SQUARE_BIT = 7;
  localparam logic [7:0] MOD_CTRL_RESET = 8'h00;
  localparam logic [7:0] DRV_CTRL_RESET = 8'h00;
  // Lead angle: 0..31 -> 0..58 degrees of a 0..383 angle (6 sectors x 64)
  localparam logic [8:0] ANGLE_FULL = 9'h180;
  localparam logic [8:0] SECTOR_STEP = 9'h040;

  typedef enum logic [1:0] {
    SWD_SQUARE = 2'b00,
    SWD_SINE = 2'b01
  } swd_mode_t;

  typedef struct packed {
    logic [1:0] predict_range_sel;
    logic [4:0] lead_angle_code;
    logic [7:0] modulation_ctrl_reg;
    logic [7:0] drive_ctrl_reg;
    logic [7:0] duty_code;
    logic serial_mode;
  } swd_cfg_t;

  typedef struct packed {
    logic u_hi;
    logic u_lo;
    logic v_hi;
    logic v_lo;
    logic w_hi;
    logic w_lo;
  } swd_gate_t;
endpackage

// ### src/swd_svm.sv
// Purpose: Space-vector modulator, angle to three phase levels
// Assumes: Angle 0..383 in sixty-four steps per sixty degrees
// Notes: Min-max injected sine, 6-bit output levels
`timescale 1ns/1ps
`default_nettype none
module swd_svm (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [8:0] angle,
  input wire logic [7:0] amp,
  output logic [5:0] mod_u,
  output logic [5:0] mod_v,
  output logic [5:0] mod_w
);
  import swd_pkg::*;

  // ----------------------------------------
  // Sine approximation
  // ----------------------------------------
  // Triangle-shaped sine is cheap; SVM injection rounds the flat top
  function automatic logic signed [7:0] tri_sin(input logic [8:0] a);
    logic [8:0] m;
    m = (a >= ANGLE_FULL) ? 9'(a - ANGLE_FULL) : a;
    if (m < 9'h060) tri_sin = 8'(m);
    else if (m < 9'h120) tri_sin = 8'(9'h0C0 - m);
    else tri_sin = 8'(m - 9'h180);
  endfunction

  function automatic logic [8:0] add_ang(input logic [8:0] a,
                                          input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    add_ang = (s >= {1'b0, ANGLE_FULL}) ? 9'(s - {1'b0, ANGLE_FULL})
                                        : 9'(s);
  endfunction

  logic signed [7:0] su, sv, sw, smax, smin, off;
  logic signed [15:0] pu, pv, pw;

  always_comb begin
    su = tri_sin(angle);
    sv = tri_sin(add_ang(angle, 9'h100));
    sw = tri_sin(add_ang(angle, 9'h080));
    smax = (su > sv) ? su : sv;
    smax = (sw > smax) ? sw : smax;
    smin = (su < sv) ? su : sv;
    smin = (sw < smin) ? sw : smin;
    off = 8'((16'(smax) + 16'(smin)) >>> 1);
    pu = 16'(su - off) * $signed({1'b0, amp});
    pv = 16'(sv - off) * $signed({1'b0, amp});
    pw = 16'(sw - off) * $signed({1'b0, amp});
  end

  // ----------------------------------------
  // Registered levels centred at half carrier
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mod_u <= 6'h20;
      mod_v <= 6'h20;
      mod_w <= 6'h20;
    end else begin
      mod_u <= 6'(7'sh20 + 7'(pu >>> 10));
      mod_v <= 6'(7'sh20 + 7'(pv >>> 10));
      mod_w <= 6'(7'sh20 + 7'(pw >>> 10));
    end
  end
endmodule  // swd_svm
`default_nettype wire

// ### src/swd_drive_gen.sv
// Purpose: Sine-wave drive generator: angle predictor, mode select, PWM
// Assumes: Hall pins and levels asynchronous; analogue levels as codes
// Notes: Square-wave output is six-step high-side PWM, complement on the low side of the same leg
// Function
// - Each sixty-degree Hall change is the reference for angle prediction.
// - Two-bit range field selects Hall frequency range tracked by predictor.
// - Range field resets to 00, the 0.8 to 80 Hz range.
// - Automatic sine drive only while predicted angle matches Hall pattern.
// - Sine entry needs hit, lead level above 0.3 V, duty above 0.75 V; the logic uses the 0.2 V lead code for entry.
// - Sine left when duty below 0.65 V or lead below 0.2 V.
// - Square force wins; else manual bit lets forced-sine bit pick mode.
// - Manual bit 7, forced-sine bit 6; square force drive bit 7.
// - Modulator turns predicted angle into three phase levels U, V, W.
// - PWM compares levels with triangle carrier driving six gate outputs.
// - Lead shift of 0 to 58 degrees from pin level or register code.
// - Host reads current, then writes lead code instead of the pin.
// - Duty condition taken from duty pin or duty register code.
// - Triangle carrier period is 64 system clocks.
// - Motor always starts in six-step square drive; manual forced-sine in serial mode selects sine even at standstill.
`timescale 1ns/1ps
`default_nettype none
module swd_drive_gen (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] hall_inputs,
  input wire logic [4:0] lead_angle_input,
  input wire logic [7:0] duty_input,
  input wire logic [7:0] current_sense_out,
  input wire swd_pkg::swd_cfg_t cfg,
  output var swd_pkg::swd_gate_t gates,
  output logic sine_active,
  output logic predict_hit,
  output logic [7:0] current_readback_reg,
  output logic [15:0] hall_period
);
  import swd_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] hall_s1_reg, hall_s2_reg, hall_prev_reg;
  logic [4:0] lead_s1_reg, lead_s2_reg;
  logic [7:0] duty_s1_reg, duty_s2_reg, cur_s1_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hall_s1_reg <= 3'h0;
      hall_s2_reg <= 3'h0;
      lead_s1_reg <= 5'h00;
      lead_s2_reg <= 5'h00;
      duty_s1_reg <= 8'h00;
      duty_s2_reg <= 8'h00;
      cur_s1_reg <= 8'h00;
      current_readback_reg <= 8'h00;
    end else begin
      hall_s1_reg <= hall_inputs;
      hall_s2_reg <= hall_s1_reg;
      lead_s1_reg <= lead_angle_input;
      lead_s2_reg <= lead_s1_reg;
      duty_s1_reg <= duty_input;
      duty_s2_reg <= duty_s1_reg;
      cur_s1_reg <= current_sense_out;
      current_readback_reg <= cur_s1_reg;
    end
  end

  // Level codes cross as words; accept one only after two equal reads
  // so a torn sample never reaches a threshold compare
  logic [4:0] lead_s3_reg, lead_lvl_reg;
  logic [7:0] duty_s3_reg, duty_lvl_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lead_s3_reg <= 5'h00;
      duty_s3_reg <= 8'h00;
      lead_lvl_reg <= 5'h00;
      duty_lvl_reg <= 8'h00;
    end else begin
      lead_s3_reg <= lead_s2_reg;
      duty_s3_reg <= duty_s2_reg;
      if (lead_s2_reg == lead_s3_reg) lead_lvl_reg <= lead_s2_reg;
      if (duty_s2_reg == duty_s3_reg) duty_lvl_reg <= duty_s2_reg;
    end
  end

  // Hall pattern to sector 0..5, 7 = invalid
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'b001: hall_sector = 3'h0;
      3'b011: hall_sector = 3'h1;
      3'b010: hall_sector = 3'h2;
      3'b110: hall_sector = 3'h3;
      3'b100: hall_sector = 3'h4;
      3'b101: hall_sector = 3'h5;
      default: hall_sector = 3'h7;
    endcase
  endfunction

  // ----------------------------------------
  // Angle predictor
  // ----------------------------------------
  logic hall_edge;
  logic [2:0] sector;
  logic [3:0] presc_reg, presc_top;
  logic [15:0] per_cnt_reg;
  logic [21:0] frac_reg;
  logic [5:0] sub_angle_reg;
  logic [8:0] base_angle, angle_next;
  logic [9:0] lead_shift;
  logic [4:0] lead_code;
  assign sector = hall_sector(hall_s2_reg);
  // Reset value of the previous pattern is no Hall code; no false edge
  assign hall_edge = (hall_s2_reg != hall_prev_reg) &&
                     (hall_sector(hall_prev_reg) != 3'h7);
  assign lead_code = cfg.serial_mode ? cfg.lead_angle_code
                                     : lead_lvl_reg;
  always_comb begin
    case (cfg.predict_range_sel)
      RANGE_RESET: presc_top = PRESC_R00;
      2'b01: presc_top = PRESC_R01;
      default: presc_top = PRESC_R1X;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hall_prev_reg <= 3'h0;
      presc_reg <= 4'h0;
      per_cnt_reg <= 16'h0000;
      hall_period <= HALL_PER_MAX;
      frac_reg <= 22'h0;
      sub_angle_reg <= 6'h00;
      predict_hit <= 1'b0;
    end else begin
      hall_prev_reg <= hall_s2_reg;
      presc_reg <= (presc_reg >= presc_top) ? 4'h0 : 4'(presc_reg + 4'h1);
      if (hall_edge) begin
        hall_period <= per_cnt_reg;
        per_cnt_reg <= 16'h0000;
        frac_reg <= 22'h0;
        // Hit: prediction had run at least 56 of the 64 sector steps on the last period
        predict_hit <= (sub_angle_reg >= 6'h38) && (sector != 3'h7) &&
                       (per_cnt_reg >= HALL_PER_MIN) &&
                       (per_cnt_reg != HALL_PER_MAX);
        sub_angle_reg <= 6'h00;
      end else if (presc_reg == 4'h0) begin
        if (per_cnt_reg != HALL_PER_MAX) begin
          per_cnt_reg <= 16'(per_cnt_reg + 16'h1);
        end else begin
          predict_hit <= 1'b0;
        end
        if (frac_reg + 22'h40 >= {6'h0, hall_period}) begin
          frac_reg <= 22'(frac_reg + 22'h40 - {6'h0, hall_period});
          if (sub_angle_reg != 6'h3F) begin
            sub_angle_reg <= 6'(sub_angle_reg + 6'h1);
          end
        end else begin
          frac_reg <= 22'(frac_reg + 22'h40);
        end
      end
    end
  end

  // Lead 0..31 codes -> 0..62 steps, i.e. about 0..58 degrees
  always_comb begin
    base_angle = 9'(({6'h0, sector} * 9'(SECTOR_STEP)) + 9'(sub_angle_reg));
    lead_shift = 10'(base_angle) + {4'h0, lead_code, 1'b0};
    angle_next = (lead_shift >= 10'(ANGLE_FULL)) ?
                 9'(lead_shift - 10'(ANGLE_FULL)) : 9'(lead_shift);
  end

  logic [5:0] mod_u, mod_v, mod_w;
  logic [7:0] duty_code;
  assign duty_code = cfg.serial_mode ? cfg.duty_code : duty_lvl_reg;

  swd_svm u_svm (
    .clk_sys(clk_sys),
    .srst(srst),
    .angle(angle_next),
    .amp(duty_code),
    .mod_u(mod_u),
    .mod_v(mod_v),
    .mod_w(mod_w)
  );

  // ----------------------------------------
  // Triangle carrier
  // ----------------------------------------
  logic [5:0] car_cnt_reg;
  logic [5:0] tri_lvl;
  logic period_end;
  always_ff @(posedge clk_sys) begin
    if (srst) car_cnt_reg <= 6'h00;
    else car_cnt_reg <= 6'(car_cnt_reg + 6'h1);
  end
  assign period_end = (car_cnt_reg == 6'(PWM_PERIOD_CYC - 1));
  assign tri_lvl = car_cnt_reg[5] ? 6'({~car_cnt_reg[4:0], 1'b1})
                                  : 6'({car_cnt_reg[4:0], 1'b0});

  // ----------------------------------------
  // Mode select
  // ----------------------------------------
  logic auto_on, auto_off, want_sine;
  logic auto_state_reg;
  swd_mode_t mode_reg;
  // Fixed code compares stand in for the analogue comparators
  assign auto_on = predict_hit && (lead_code > LEAD_OFF_CODE) &&
                   (duty_code > DUTY_ON_CODE);
  assign auto_off = !predict_hit || (duty_code < DUTY_OFF_CODE) ||
                    (lead_code <= LEAD_OFF_CODE);
  always_ff @(posedge clk_sys) begin
    if (srst) auto_state_reg <= 1'b0;
    else if (auto_off) auto_state_reg <= 1'b0;
    else if (auto_on) auto_state_reg <= 1'b1;
  end
  always_comb begin
    if (cfg.serial_mode && cfg.drive_ctrl_reg[DRV_SQUARE_BIT])
      want_sine = 1'b0;
    else if (cfg.serial_mode && cfg.modulation_ctrl_reg[MOD_MANUAL_BIT])
      want_sine = cfg.modulation_ctrl_reg[MOD_FORCE_SINE_BIT];
    else
      want_sine = auto_state_reg;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_reg <= SWD_SQUARE;
    end else if (period_end) begin
      case (mode_reg)
        SWD_SQUARE: mode_reg <= want_sine ? SWD_SINE : SWD_SQUARE;
        SWD_SINE: mode_reg <= want_sine ? SWD_SINE : SWD_SQUARE;
        default: mode_reg <= SWD_SQUARE;
      endcase
    end
  end
  // Flag kept in its own flop, changing on the same edge as the mode
  always_ff @(posedge clk_sys) begin
    if (srst) sine_active <= 1'b0;
    else if (period_end) sine_active <= want_sine;
  end

  // ----------------------------------------
  // Gate outputs
  // ----------------------------------------
  logic sq_pwm;
  assign sq_pwm = ({2'h0, tri_lvl} < duty_code[7:0] >> 2);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gates <= '0;
    end else if (mode_reg == SWD_SINE) begin
      gates.u_hi <= mod_u > tri_lvl;
      gates.u_lo <= !(mod_u > tri_lvl);
      gates.v_hi <= mod_v > tri_lvl;
      gates.v_lo <= !(mod_v > tri_lvl);
      gates.w_hi <= mod_w > tri_lvl;
      gates.w_lo <= !(mod_w > tri_lvl);
    end else begin
      // Six-step: PWM high side, complement on same leg, one low side on
      gates.u_hi <= (sector == 3'h0 || sector == 3'h1) && sq_pwm;
      gates.u_lo <= (sector == 3'h0 || sector == 3'h1) ? !sq_pwm
                    : (sector == 3'h3 || sector == 3'h4);
      gates.v_hi <= (sector == 3'h2 || sector == 3'h3) && sq_pwm;
      gates.v_lo <= (sector == 3'h2 || sector == 3'h3) ? !sq_pwm
                    : (sector == 3'h5 || sector == 3'h0);
      gates.w_hi <= (sector == 3'h4 || sector == 3'h5) && sq_pwm;
      gates.w_lo <= (sector == 3'h4 || sector == 3'h5) ? !sq_pwm
                    : (sector == 3'h1 || sector == 3'h2);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MODE_AT_BOUNDARY: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(mode_reg) |-> $past(period_end)) else
    $error("Mode changed off a carrier boundary");
  AST_SQUARE_FORCE: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg.serial_mode && cfg.drive_ctrl_reg[DRV_SQUARE_BIT]) [*2]
    ##0 period_end |=> !sine_active) else
    $error("Square force did not stop sine drive");
  AST_AUTO_NEEDS_HIT: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(auto_state_reg) |-> $past(predict_hit)) else
    $error("Automatic sine without prediction hit");
  AST_ENTRY_LEVELS: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(auto_state_reg) |-> $past(duty_code) > DUTY_ON_CODE) else
    $error("Sine entry below duty threshold");
  AST_EXIT_DUTY: assert property (@(posedge clk_sys) disable iff (srst)
    duty_code < DUTY_OFF_CODE |=> !auto_state_reg) else
    $error("Sine kept with duty below exit level");
  AST_CARRIER_PERIOD: assert property (@(posedge clk_sys) disable iff (srst)
    period_end |=> !period_end [*8] ##56 period_end) else
    $error("Carrier period not 64 cycles");
  AST_RANGE_PRESC: assert property (@(posedge clk_sys) disable iff (srst)
    cfg.predict_range_sel == 2'b01 |-> presc_top == 4'h7) else
    $error("Wrong prescale for range 01");
  AST_GATE_NO_SHOOT: assert property (@(posedge clk_sys) disable iff (srst)
    !(gates.u_hi && gates.u_lo) && !(gates.v_hi && gates.v_lo) &&
    !(gates.w_hi && gates.w_lo)) else
    $error("High and low side on together");
endmodule  // swd_drive_gen
`default_nettype wire

// ### testbench/swd_hall_model.sv
// Purpose: Hall sensor model, steps the six valid sector codes
// Assumes: One sector step every step_cyc system clocks while run is high
// Notes: Pins always driven, the sensors hold their level between steps
`timescale 1ns/1ps
`default_nettype none
module swd_hall_model (
  input wire logic clk_sys,
  input wire logic run,
  input var int step_cyc,
  output logic [2:0] hall_inputs
);
  // ----------------------------------------
  // Sector sequencer
  // ----------------------------------------
  logic [2:0] seq [0:5];
  int cnt_reg = 0;
  int idx_reg = 0;
  initial begin
    seq[0] = 3'h1;
    seq[1] = 3'h3;
    seq[2] = 3'h2;
    seq[3] = 3'h6;
    seq[4] = 3'h4;
    seq[5] = 3'h5;
  end
  // One change every sixty degrees
  always_ff @(posedge clk_sys) begin
    if (!run) begin
      cnt_reg <= 0;
    end else if (cnt_reg == step_cyc - 1) begin
      cnt_reg <= 0;
      idx_reg <= (idx_reg == 5) ? 0 : idx_reg + 1;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  assign hall_inputs = seq[idx_reg];
endmodule // swd_hall_model
`default_nettype wire

// ### testbench/swd_drive_gen_tb.sv
// Purpose: Self-checking bench for the sine-wave drive generator
// Assumes: Fixed Hall step of 2000 clocks, no parameters shortened
// Notes: Mode timing checked against the 64-clock carrier period
`timescale 1ns/1ps
`default_nettype none
module swd_drive_gen_tb;
  import swd_pkg::*;
  logic clk_sys;
  logic srst = 1'b1;
  logic [2:0] hall_inputs;
  logic [4:0] lead_in = 5'h00;
  logic [7:0] duty_in = 8'h00;
  logic [7:0] cur = 8'h00;
  swd_cfg_t cfg = '0;
  swd_gate_t gates;
  logic sine_active;
  logic predict_hit;
  logic [7:0] rb;
  logic [15:0] hper;
  logic run = 1'b0;
  int step_cyc = 2000;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1;
  int ups;
  int ups_v;
  int ups_w;
  logic ok;
  logic ok_v;
  logic ok_w;
  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Ceiling well above the longest sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  swd_hall_model i_hall (.clk_sys(clk_sys), .run(run),
    .step_cyc(step_cyc), .hall_inputs(hall_inputs));
  swd_drive_gen i_dut (.clk_sys(clk_sys), .srst(srst),
    .hall_inputs(hall_inputs), .lead_angle_input(lead_in),
    .duty_input(duty_in), .current_sense_out(cur), .cfg(cfg),
    .gates(gates), .sine_active(sine_active), .predict_hit(predict_hit),
    .current_readback_reg(rb), .hall_period(hper));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait on the mode flag
  task automatic wait_sine(input logic v, input int n);
    int i;
    for (i = 0; i < n && sine_active !== v; i++) begin
      tick(1);
    end
    check({15'h0, sine_active}, {15'h0, v});
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    cfg.predict_range_sel = RANGE_RESET;
    tick(3);
    srst = 1'b0;
    check({10'h0, gates}, 16'h0000);
    check({15'h0, sine_active}, 16'h0000);
    check({15'h0, predict_hit}, 16'h0000);
    check(hper, 16'hFFFF);
    cur = 8'h5A;
    tick(4);
    check({8'h0, rb}, 16'h005A);
    // Sector 0 at zero duty: U high off, U and V low sides on
    check({10'h0, gates}, 16'h0014);
    // Square force must beat forced sine
    cfg.serial_mode = 1'b1;
    cfg.modulation_ctrl_reg = 8'hC0;
    cfg.drive_ctrl_reg = 8'h80;
    tick(200);
    check({15'h0, sine_active}, 16'h0000);
    cfg.drive_ctrl_reg = 8'h00;
    wait_sine(1'b1, 130);
    t1 = cyc;
    cfg.modulation_ctrl_reg = 8'h80;
    wait_sine(1'b0, 130);
    check(16'((cyc - t1) % 64), 16'h0000);
    // Automatic mode from pins with a turning rotor
    cfg.modulation_ctrl_reg = 8'h00;
    cfg.serial_mode = 1'b0;
    duty_in = 8'h40;
    lead_in = 5'h05;
    run = 1'b1;
    wait_sine(1'b1, 20000);
    check({15'h0, predict_hit}, 16'h0001);
    ups = 0;
    ups_v = 0;
    ups_w = 0;
    repeat (400) begin
      ok = gates.u_hi;
      ok_v = gates.v_hi;
      ok_w = gates.w_hi;
      tick(1);
      if (!ok && gates.u_hi === 1'b1) ups++;
      if (!ok_v && gates.v_hi === 1'b1) ups_v++;
      if (!ok_w && gates.w_hi === 1'b1) ups_w++;
    end
    check({15'h0, ups > 3}, 16'h0001);
    check({15'h0, ups_v > 3}, 16'h0001);
    check({15'h0, ups_w > 3}, 16'h0001);
    duty_in = 8'h05;
    wait_sine(1'b0, 130);
    // Between the two thresholds the flag must stay low
    duty_in = 8'h0C;
    tick(300);
    check({15'h0, sine_active}, 16'h0000);
    duty_in = 8'h20;
    wait_sine(1'b1, 300);
    lead_in = 5'h00;
    wait_sine(1'b0, 130);
    // Register codes take over from the pins
    cfg.serial_mode = 1'b1;
    cfg.duty_code = 8'h40;
    cfg.lead_angle_code = 5'h1F;
    duty_in = 8'h00;
    wait_sine(1'b1, 300);
    cfg.duty_code = 8'h05;
    wait_sine(1'b0, 130);
    // Prescale per range: 00 /4, 01 /8, 1x /1
    for (int r = 0; r < 4; r++) begin
      cfg.predict_range_sel = 2'(r);
      tick(4500);
      t1 = (r == 0) ? 500 : (r == 1) ? 250 : 2000;
      ok = (int'(hper) >= t1 - 4) && (int'(hper) <= t1 + 4);
      check({15'h0, ok}, 16'h0001);
    end
    end_of_test();
  end
endmodule // swd_drive_gen_tb
`default_nettype wire
